/* File: smr_assertions.sv */
`timescale 1ns/1ps
module smr_assertions (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        ce_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_we_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [31:0] mem_addr_i,
  input wire logic        mem_we_i,
  input wire logic        mem_req_i,
  input wire logic        mem_ack_o,
  input wire logic [2:0]  sdram_cmd_o,
  input wire logic [10:0] sdram_addr_o
);
  logic [10:0] map_w;
  logic        acc_w;
  assign map_w = {mem_addr_i[20:17], mem_addr_i[9], mem_addr_i[10], mem_addr_i[11],
                  mem_addr_i[12], mem_addr_i[13], mem_addr_i[14], mem_addr_i[15]};
  // Refresh is left out: it needs no processor request
  assign acc_w = sdram_cmd_o inside {smr_pkg::CMD_MODE_SET, smr_pkg::CMD_PRECHARGE,
                                     smr_pkg::CMD_WRITE, smr_pkg::CMD_READ};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_mrs_map; sdram_cmd_o == smr_pkg::CMD_MODE_SET |-> sdram_addr_o == map_w; endproperty
  a_mrs_map: assert property (p_mrs_map) else $error("mode set address map wrong");
  property p_pre; sdram_cmd_o == smr_pkg::CMD_PRECHARGE |-> sdram_addr_o[10] && mem_we_i; endproperty
  a_pre: assert property (p_pre) else $error("precharge without write or line 10");
  property p_req; acc_w |-> $past(mem_req_i) && mem_req_i; endproperty
  a_req: assert property (p_req) else $error("command without access");
  property p_gap; sdram_cmd_o != smr_pkg::CMD_NOP |=> sdram_cmd_o == smr_pkg::CMD_NOP [*2]; endproperty
  a_gap: assert property (p_gap) else $error("command during busy");
  property p_lat; acc_w |-> ##4 mem_ack_o; endproperty
  a_lat: assert property (p_lat) else $error("access ack late");
  property p_once; mem_ack_o |-> !acc_w; endproperty
  a_once: assert property (p_once) else $error("second command for one access");
  property p_drop; mem_ack_o && !mem_req_i |=> !mem_ack_o; endproperty
  a_drop: assert property (p_drop) else $error("access ack stuck");
  property p_norm; sdram_cmd_o == smr_pkg::CMD_WRITE |-> sdram_addr_o == mem_addr_i[10:0]; endproperty
  a_norm: assert property (p_norm) else $error("normal write address wrong");
  property p_wb; ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_wb: assert property (p_wb) else $error("bus ack not one cycle");
endmodule : smr_assertions

/* File: smr_cmd_if.sv */
`timescale 1ns/1ps
interface smr_cmd_if;
  logic        fire;
  logic [2:0]  cmd;
  logic [31:0] addr;
  logic [2:0]  sdram_cmd;
  logic [10:0] sdram_addr;
  logic        busy;
  logic        done;

  modport ctrl (output fire, output cmd, output addr, input sdram_cmd, input sdram_addr, input busy, input done);
  modport seq  (input fire, input cmd, input addr, output sdram_cmd, output sdram_addr, output busy, output done);
endinterface : smr_cmd_if

/* File: smr_cmd_seq.sv */
`timescale 1ns/1ps
module smr_cmd_seq (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  smr_cmd_if.seq    cif
);

  logic [2:0]  cnt_r,  cnt_nxt;
  logic [2:0]  cmd_r,  cmd_nxt;
  logic [10:0] adr_r,  adr_nxt;
  logic        done_r, done_nxt;
  logic [10:0] mapped;

  always_comb
  begin
    mapped = cif.addr[10:0];
    if (cif.cmd == smr_pkg::CMD_MODE_SET)
    begin
      mapped[10]  = cif.addr[20];
      mapped[9:7] = cif.addr[19:17];
      mapped[6:0] = {cif.addr[9], cif.addr[10], cif.addr[11], cif.addr[12],
                     cif.addr[13], cif.addr[14], cif.addr[15]};
    end
    else if (cif.cmd == smr_pkg::CMD_PRECHARGE)
    begin
      mapped[10] = 1'b1;
    end
  end

  always_comb
  begin
    cnt_nxt  = cnt_r;
    cmd_nxt  = smr_pkg::CMD_NOP;
    adr_nxt  = adr_r;
    done_nxt = 1'b0;
    if (cnt_r != 3'h0)
    begin
      cnt_nxt  = cnt_r - 3'h1;
      done_nxt = (cnt_r == 3'h1);
    end
    else if (cif.fire)
    begin
      // Command only on the first cycle; the rest are settle time
      cnt_nxt = smr_pkg::CMD_CYCLES;
      cmd_nxt = cif.cmd;
      adr_nxt = mapped;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cnt_r  <= 3'h0;
      cmd_r  <= smr_pkg::CMD_NOP;
      adr_r  <= 11'h000;
      done_r <= 1'b0;
    end
    else if (ce_i)
    begin
      cnt_r  <= cnt_nxt;
      cmd_r  <= cmd_nxt;
      adr_r  <= adr_nxt;
      done_r <= done_nxt;
    end
  end

  assign cif.sdram_cmd  = cmd_r;
  assign cif.sdram_addr = adr_r;
  assign cif.busy       = (cnt_r != 3'h0);
  assign cif.done       = done_r;

endmodule : smr_cmd_seq

/* File: smr_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - While the mode-set request is set, the next access hitting the SDRAM becomes a mode register set command.
// - During mode set, SDRAM line 10 carries processor address bit 20.
// - Processor bits 19..17 go to lines 9..7 and bits 9..15 go to lines 6 down to 0.
// - With the precharge request set and the mode-set request clear, a write to SDRAM issues precharge-all instead of storing data.
// - The mode-set request bit reads 0 when no mode set command is pending.
// - The precharge request bit reads 0 when no precharge is pending.
module smr_ctrl (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        ce_i,
  // Wishbone register slave
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Memory access port from the processor bus
  input  wire logic [31:0] mem_addr_i,
  input  wire logic        mem_we_i,
  input  wire logic        mem_req_i,
  output logic             mem_ack_o,
  // SDRAM command pins
  output logic      [2:0]  sdram_cmd_o,
  output logic      [10:0] sdram_addr_o
);

  smr_cmd_if cif ();

  smr_cmd_seq u_seq (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .ce_i      (ce_i),
    .cif       (cif)
  );

  logic [15:0] refresh_ctrl_r, refresh_ctrl_nxt;
  logic [31:0] base_ctrl_r,    base_ctrl_nxt;
  logic [31:0] addr_mask_r,    addr_mask_nxt;
  logic [31:0] rdat_r,         rdat_nxt;
  logic        ack_r,          ack_nxt;
  logic [12:0] rcnt_r,         rcnt_nxt;
  logic        rpend_r,        rpend_nxt;
  logic [31:0] bus_wdat;
  logic [31:0] cur_rd;
  logic        wb_wr;
  logic [31:0] hit_mask;
  logic        hit;
  logic        fire_c;
  logic [2:0]  cmd_c;
  logic        fire_ack;
  smr_pkg::smr_state_t st_r, st_nxt;

  // Byte-lane merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign wb_wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;

  always_comb
  begin
    case (wb_adr_i)
      smr_pkg::REFRESH_CTRL_OFS: cur_rd = {16'h0000, refresh_ctrl_r};
      smr_pkg::BASE_CTRL_OFS:    cur_rd = base_ctrl_r;
      smr_pkg::ADDR_MASK_OFS:    cur_rd = addr_mask_r;
      smr_pkg::STATUS_OFS:       cur_rd = {29'h0000_0000, rpend_r, cif.busy, (st_r != smr_pkg::ST_IDLE)};
      default:                   cur_rd = 32'h0000_0000;
    endcase
  end
  assign bus_wdat = merge(cur_rd, wb_dat_i, wb_sel_i);

  // Address decode: mask bits set in the mask register are don't-care
  assign hit_mask = {addr_mask_r[31:16] | 16'h0003, 16'h0000};
  assign hit      = addr_mask_r[smr_pkg::MASK_VALID_BIT] &&
                    (((mem_addr_i ^ base_ctrl_r) & ~hit_mask & 32'hFFFC_0000) == 32'h0000_0000);

  // Refresh counter, request held pending while a special command runs
  always_comb
  begin
    rcnt_nxt  = rcnt_r;
    rpend_nxt = rpend_r;
    // Clear first so a period that expires on the serviced cycle is not lost
    if (fire_c && cmd_c == smr_pkg::CMD_REFRESH)
    begin
      rpend_nxt = 1'b0;
    end
    if (!base_ctrl_r[smr_pkg::REFRESH_EN_BIT])
    begin
      rcnt_nxt  = 13'h0000;
      rpend_nxt = 1'b0;
    end
    else if (rcnt_r == 13'h0000)
    begin
      // Period is (count field + 1) * 16 clocks
      rcnt_nxt  = 13'((refresh_ctrl_r[smr_pkg::REFRESH_CNT_HI:0] + 9'h001) * smr_pkg::REFRESH_UNIT_CYC - 1);
      rpend_nxt = 1'b1;
    end
    else
    begin
      rcnt_nxt = rcnt_r - 13'h0001;
    end
  end

  // Access arbiter: a hitting processor access outranks a pending refresh
  always_comb
  begin
    st_nxt   = st_r;
    fire_c   = 1'b0;
    cmd_c    = smr_pkg::CMD_NOP;
    fire_ack = 1'b0;
    case (st_r)
      smr_pkg::ST_IDLE:
      begin
        if (cif.busy)
        begin
          st_nxt = smr_pkg::ST_IDLE;
        end
        else if (rpend_r && !(mem_req_i && hit))
        begin
          fire_c = 1'b1;
          cmd_c  = smr_pkg::CMD_REFRESH;
        end
        else if (mem_req_i && hit)
        begin
          fire_c = 1'b1;
          st_nxt = smr_pkg::ST_HOLD;
          if (base_ctrl_r[smr_pkg::MODE_SET_BIT])
          begin
            cmd_c = smr_pkg::CMD_MODE_SET;
          end
          else if (base_ctrl_r[smr_pkg::PRECHARGE_BIT] && mem_we_i)
          begin
            cmd_c = smr_pkg::CMD_PRECHARGE;
          end
          else
          begin
            cmd_c = mem_we_i ? smr_pkg::CMD_WRITE : smr_pkg::CMD_READ;
          end
        end
      end
      smr_pkg::ST_HOLD:
      begin
        if (cif.done)
        begin
          st_nxt   = smr_pkg::ST_ACK;
          fire_ack = 1'b1;
        end
      end
      smr_pkg::ST_ACK:
      begin
        // Wait for the bus to drop the request so one access gives one command
        if (!mem_req_i)
        begin
          st_nxt = smr_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_nxt = smr_pkg::ST_IDLE;
      end
    endcase
  end

  assign cif.fire = fire_c;
  assign cif.cmd  = cmd_c;
  assign cif.addr = mem_addr_i;

  // Register file; hardware clear of a request bit loses to a software set
  always_comb
  begin
    refresh_ctrl_nxt = refresh_ctrl_r;
    base_ctrl_nxt    = base_ctrl_r;
    addr_mask_nxt    = addr_mask_r;
    ack_nxt          = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt         = cur_rd;
    if (fire_c && cmd_c == smr_pkg::CMD_MODE_SET)
    begin
      base_ctrl_nxt[smr_pkg::MODE_SET_BIT] = 1'b0;
    end
    if (fire_c && cmd_c == smr_pkg::CMD_PRECHARGE)
    begin
      base_ctrl_nxt[smr_pkg::PRECHARGE_BIT] = 1'b0;
    end
    if (wb_wr)
    begin
      case (wb_adr_i)
        smr_pkg::REFRESH_CTRL_OFS: refresh_ctrl_nxt = bus_wdat[15:0];
        smr_pkg::BASE_CTRL_OFS:    base_ctrl_nxt    = bus_wdat;
        smr_pkg::ADDR_MASK_OFS:    addr_mask_nxt    = bus_wdat;
        default:                   refresh_ctrl_nxt = refresh_ctrl_r;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      refresh_ctrl_r <= smr_pkg::REFRESH_CTRL_RST;
      base_ctrl_r    <= smr_pkg::BASE_CTRL_RST;
      addr_mask_r    <= smr_pkg::ADDR_MASK_RST;
      rdat_r         <= 32'h0000_0000;
      ack_r          <= 1'b0;
      rcnt_r         <= 13'h0000;
      rpend_r        <= 1'b0;
      st_r           <= smr_pkg::ST_IDLE;
    end
    else if (ce_i)
    begin
      refresh_ctrl_r <= refresh_ctrl_nxt;
      base_ctrl_r    <= base_ctrl_nxt;
      addr_mask_r    <= addr_mask_nxt;
      rdat_r         <= rdat_nxt;
      ack_r          <= ack_nxt;
      rcnt_r         <= rcnt_nxt;
      rpend_r        <= rpend_nxt;
      st_r           <= st_nxt;
    end
  end

  assign wb_dat_o     = rdat_r;
  assign wb_ack_o     = ack_r;
  assign mem_ack_o    = (st_r == smr_pkg::ST_ACK);
  assign sdram_cmd_o  = cif.sdram_cmd;
  assign sdram_addr_o = cif.sdram_addr;

endmodule : smr_ctrl

/* File: smr_pkg.sv */
package smr_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [3:0] REFRESH_CTRL_OFS = 4'h0;
  localparam logic [3:0] BASE_CTRL_OFS    = 4'h4;
  localparam logic [3:0] ADDR_MASK_OFS    = 4'h8;
  localparam logic [3:0] STATUS_OFS       = 4'hC;

  // Base/control register fields, plus refresh count field and mask valid bit
  localparam int BA_HI           = 31;
  localparam int BA_LO           = 18;
  localparam int REFRESH_EN_BIT  = 15;
  localparam int MODE_SET_BIT    = 6;
  localparam int PRECHARGE_BIT   = 3;
  localparam int REFRESH_CNT_HI  = 8;
  localparam int MASK_VALID_BIT  = 0;

  // Values after reset
  localparam logic [31:0] BASE_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] ADDR_MASK_RST    = 32'h0000_0000;
  localparam logic [15:0] REFRESH_CTRL_RST = 16'h0000;

  // Refresh period unit and command length
  localparam int          REFRESH_UNIT_CYC = 16;
  localparam logic [2:0]  CMD_CYCLES       = 3'h3;

  // SDRAM command encodings {ras_n, cas_n, we_n}
  localparam logic [2:0] CMD_NOP       = 3'h7;
  localparam logic [2:0] CMD_PRECHARGE = 3'h2;
  localparam logic [2:0] CMD_REFRESH   = 3'h1;
  localparam logic [2:0] CMD_MODE_SET  = 3'h0;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_READ      = 3'h5;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'b0001,
    ST_ISSUE   = 4'b0010,
    ST_HOLD    = 4'b0100,
    ST_ACK     = 4'b1000
  } smr_state_t;

endpackage : smr_pkg

/* File: smr_sdram_model.sv */
`timescale 1ns/1ps
module smr_sdram_model (
  input  wire logic        clk_i,
  input  wire logic [2:0]  cmd_i,
  input  wire logic [10:0] addr_i,
  output logic      [2:0]  last_cmd_o,
  output logic      [10:0] last_addr_o,
  output logic      [10:0] mode_o,
  output int               n_acc_o,
  output int               n_ref_o
);
  initial
  begin
    n_acc_o = 0;
    n_ref_o = 0;
  end
  always @(posedge clk_i)
  begin
    if (cmd_i == smr_pkg::CMD_REFRESH)
      n_ref_o <= n_ref_o + 1;
    else if (cmd_i != smr_pkg::CMD_NOP)
    begin
      last_cmd_o  <= cmd_i;
      last_addr_o <= addr_i;
      n_acc_o     <= n_acc_o + 1;
      if (cmd_i == smr_pkg::CMD_MODE_SET)
        mode_o <= addr_i;
    end
  end
endmodule : smr_sdram_model

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  typedef struct packed {logic [31:0] base_ctrl; logic [31:0] adr; logic we; logic [2:0] cmd; logic [10:0] sa;} smr_row_t;
  logic        clk_i = 0, reset_n_i = 0, wb_we_i = 0, wb_req = 0, mem_we_i = 0, mem_req_i = 0;
  logic [3:0]  wb_adr_i = 0;
  logic [31:0] wb_dat_i = 0, mem_addr_i = 0, wb_dat_o, rd;
  logic        wb_ack_o, mem_ack_o;
  logic [2:0]  sdram_cmd_o, l_cmd;
  logic [10:0] sdram_addr_o, l_adr, mode;
  int          n_acc, n_ref, n, errors = 0, checked = 0;
  smr_row_t    rows [8] = '{
    '{32'hFF888340, 32'hFF900000, 1'b0, smr_pkg::CMD_MODE_SET, 11'h400},
    '{32'hFF888340, 32'hFF8E0000, 1'b1, smr_pkg::CMD_MODE_SET, 11'h380},
    '{32'hFF888340, 32'hFF800200, 1'b0, smr_pkg::CMD_MODE_SET, 11'h040},
    '{32'hFF888340, 32'hFF808000, 1'b0, smr_pkg::CMD_MODE_SET, 11'h001},
    '{32'hFF888340, 32'hFF801400, 1'b0, smr_pkg::CMD_MODE_SET, 11'h028},
    '{32'hFF888308, 32'hFF880400, 1'b1, smr_pkg::CMD_PRECHARGE, 11'h400},
    '{32'hFF888308, 32'hFF8805A5, 1'b0, smr_pkg::CMD_READ, 11'h5A5},
    '{32'hFF888300, 32'hFF8807FF, 1'b1, smr_pkg::CMD_WRITE, 11'h7FF}};
  always #5 clk_i = ~clk_i;
  smr_ctrl dut_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_req), .wb_stb_i(wb_req),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_i(mem_addr_i), .mem_we_i(mem_we_i),
    .mem_req_i(mem_req_i), .mem_ack_o(mem_ack_o), .sdram_cmd_o(sdram_cmd_o), .sdram_addr_o(sdram_addr_o));
  smr_sdram_model mdl_u (.clk_i(clk_i), .cmd_i(sdram_cmd_o), .addr_i(sdram_addr_o), .last_cmd_o(l_cmd),
    .last_addr_o(l_adr), .mode_o(mode), .n_acc_o(n_acc), .n_ref_o(n_ref));
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // A refresh may already be running when a request comes, so the bound is above one refresh period
  task automatic wait_hi(input bit m);
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
      if (k > 3000)
      begin
        errors++;
        end_of_test();
      end
    end
    while ((m ? mem_ack_o : wb_ack_o) !== 1'b1);
  endtask : wait_hi
  task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_req   <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wait_hi(1'b0);
    rd = wb_dat_o;
    wb_req <= 1'b0;
  endtask : wb
  task automatic mem(input logic [31:0] a, input logic we);
    @(posedge clk_i);
    mem_addr_i <= a;
    mem_we_i   <= we;
    mem_req_i  <= 1'b1;
    wait_hi(1'b1);
    mem_req_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : mem
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wb(1'b0, smr_pkg::BASE_CTRL_OFS, 32'h0);
    check("base reset", rd, smr_pkg::BASE_CTRL_RST);
    wb(1'b1, 4'h2, 32'hFFFFFFFF);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'b1, smr_pkg::REFRESH_CTRL_OFS, 32'h8026);
    wb(1'b1, smr_pkg::BASE_CTRL_OFS, 32'hFF880300);
    wb(1'b1, smr_pkg::ADDR_MASK_OFS, 32'h00740075);
    wb(1'b1, smr_pkg::BASE_CTRL_OFS, 32'hFF880308);
    mem(32'hFF880000, 1'b1);
    check("precharge", l_cmd, smr_pkg::CMD_PRECHARGE);
    wb(1'b0, smr_pkg::BASE_CTRL_OFS, 32'h0);
    check("pre bit", rd[smr_pkg::PRECHARGE_BIT], 1'b0);
    check("no refresh", n_ref, 0);
    wb(1'b1, smr_pkg::BASE_CTRL_OFS, 32'hFF888300);
    repeat (700) @(posedge clk_i);
    check("refresh", n_ref != 0, 1);
    $display("init sequence done");
    // Bit 19 of the mask must be set or the mode access misses
    wb(1'b1, smr_pkg::ADDR_MASK_OFS, 32'h00680075);
    wb(1'b1, smr_pkg::BASE_CTRL_OFS, 32'hFF888340);
    mem(32'hFF800800, 1'b0);
    check("mode value", mode, 11'h010);
    wb(1'b0, smr_pkg::BASE_CTRL_OFS, 32'h0);
    check("mrs bit", rd[smr_pkg::MODE_SET_BIT], 1'b0);
    $display("mode set done");
    wb(1'b1, smr_pkg::ADDR_MASK_OFS, 32'h007C0075);
    foreach (rows[i])
    begin
      wb(1'b1, smr_pkg::BASE_CTRL_OFS, rows[i].base_ctrl);
      n = n_acc;
      mem(rows[i].adr, rows[i].we);
      check("cmd", l_cmd, rows[i].cmd);
      check("lines", l_adr, rows[i].sa);
      check("one cmd", n_acc - n, 1);
      wb(1'b0, smr_pkg::BASE_CTRL_OFS, 32'h0);
      check("req clr", rd, rows[i].base_ctrl & ~(rows[i].cmd == smr_pkg::CMD_MODE_SET ? 32'h40 :
            rows[i].cmd == smr_pkg::CMD_PRECHARGE ? 32'h8 : 32'h0));
      $display("row %0d done", i);
    end
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    @(posedge clk_i);
    check("reset cmd", sdram_cmd_o, smr_pkg::CMD_NOP);
    reset_n_i <= 1'b1;
    wb(1'b0, smr_pkg::BASE_CTRL_OFS, 32'h0);
    check("base after reset", rd, smr_pkg::BASE_CTRL_RST);
    wb(1'b0, smr_pkg::STATUS_OFS, 32'h0);
    check("status after reset", rd, 32'h0000_0000);
    $display("reset test done");
    end_of_test();
  end
endmodule : tb
bind smr_ctrl smr_assertions chk_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_addr_i(mem_addr_i), .mem_we_i(mem_we_i),
  .mem_req_i(mem_req_i), .mem_ack_o(mem_ack_o), .sdram_cmd_o(sdram_cmd_o), .sdram_addr_o(sdram_addr_o));
